/* File: dmx_pkg.sv */
// Constants and carrier types for the dual multiplier mixer datapath.
// How it works
// - Select code 0000 is one clock, 1111 sixteen.
// - Four registered four-bit delay selects, one per port.
// - Operand taken from pipeline stage chosen each clock.
// - Accept 16-bit cascade input, bit zero least.
// - Sum output shows chosen accumulator word.
// - Enabled port captures value and shifts pipeline.
// - Disabled port holds pipeline, drops input value.
// - Negate high subtracts its product instead.
// - First negate on AxB, second on CxD.
// - Control pipelining fixed, independent of delays.
// - Round high rounds the product sum to 16 bits.
// - Round only in first accumulation cycle.
// - Accumulate low restarts, high adds, disables rounding.
// - Cascade added only while cascade enable low.
// - Swap low toggles words, accepts no new results.
// - Output enable low drives sum, high floats it.
package dmx_pkg;
  localparam int DATA_W = 12;
  localparam int NPORT = 4;
  localparam int DEPTH = 16;
  localparam int SEL_W = 4;
  localparam int CAS_W = 16;
  localparam int PROD_W = 24;
  localparam int ACC_W = 24;
  localparam int OUT_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int CAS_LSB = 8;
  localparam int MSW_LSB = 8;
  localparam int LSW_LSB = 0;
  localparam int FILL_STAGES = 5;
  localparam logic [ACC_W-1:0] ROUND_ADD = 24'h000080;
  localparam logic [ACC_W-1:0] ACC_RESET = 24'h000000;
  localparam logic [OUT_W-1:0] SUM_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 12'h000;

  typedef logic [NPORT-1:0][DATA_W-1:0] dmx_ports_t;
  typedef logic [NPORT-1:0][SEL_W-1:0] dmx_sels_t;

  typedef struct packed {
    logic negate_first_product;
    logic negate_second_product;
    logic round_control;
    logic accumulate_control;
    logic cascade_enable_n;
  } dmx_ctrl_t;

  localparam dmx_ctrl_t CTRL_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
endpackage

/* File: dmx_mixer.sv */
// Dual multiplier mixer datapath with its result FIFO.
module dmx_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  import dmx_pkg::*;
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready_out = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = mem[rd_ptr_reg];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module dmx_mixer (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire dmx_pkg::dmx_ports_t port_data_in,
  input wire dmx_pkg::dmx_sels_t port_delay_selects_in,
  input wire logic [dmx_pkg::NPORT-1:0] port_input_enables_n_in,
  input wire dmx_pkg::dmx_ctrl_t ctrl_in,
  input wire logic [dmx_pkg::CAS_W-1:0] cascade_data_in,
  input wire logic word_swap_in,
  input wire logic output_enable_n_in,
  output logic core_ready_out,
  output logic [dmx_pkg::OUT_W-1:0] sum_out,
  output logic sum_oe_out,
  output logic sum_valid_out
);
  import dmx_pkg::*;

  // Input capture registers; every input pin except output_enable_n_in is registered.
  dmx_ports_t data_reg;
  dmx_sels_t sel_reg;
  logic [NPORT-1:0] en_n_reg;
  dmx_ctrl_t ctrl_reg;
  logic [CAS_W-1:0] cas_reg;
  logic swap_reg;

  logic [DATA_W-1:0] pipe_reg [NPORT][DEPTH];
  logic [DATA_W-1:0] operand_reg [NPORT];
  dmx_ctrl_t ctrl_op_reg;
  dmx_ctrl_t ctrl_mul_reg;
  logic [CAS_W-1:0] cas_mul_reg;
  dmx_ctrl_t ctrl_prod_reg;
  dmx_ctrl_t ctrl_sum_reg;
  logic [CAS_W-1:0] cas_op_reg;
  logic [CAS_W-1:0] cas_prod_reg;
  logic [CAS_W-1:0] cas_sum_reg;
  logic signed [PROD_W-1:0] prod_ab_reg;
  logic signed [PROD_W-1:0] prod_cd_reg;
  logic [ACC_W-1:0] sum_reg;
  logic [ACC_W-1:0] sum_next;
  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] acc_next;
  logic [ACC_W-1:0] cas_term;
  logic [FILL_STAGES-1:0] fill_reg;
  logic advance;

  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [ACC_W-1:0] fifo_out_data;
  logic [ACC_W-1:0] word_reg;
  logic show_lsw_reg;
  logic [OUT_W-1:0] sum_reg_out;
  logic sum_valid_reg;

  // The core up to the result FIFO stalls while the FIFO is full; swap_reg and the output stage keep running.
  assign core_ready_out = advance;

  // A stalled core ignores its inputs, so every capture register except swap_reg waits for advance.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data_reg <= '0;
    end else if (advance) begin
      data_reg <= port_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sel_reg <= '0;
    end else if (advance) begin
      sel_reg <= port_delay_selects_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      en_n_reg <= '1;
    end else if (advance) begin
      en_n_reg <= port_input_enables_n_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_reg <= CTRL_RESET;
    end else if (advance) begin
      ctrl_reg <= ctrl_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cas_reg <= '0;
    end else if (advance) begin
      cas_reg <= cascade_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      swap_reg <= 1'b1;
    end else begin
      swap_reg <= word_swap_in;
    end
  end

  // Per-port delay pipelines and stage selection.
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        for (int s = 0; s < DEPTH; s++) begin
          pipe_reg[p][s] <= DATA_RESET;
        end
      end else if (advance && !en_n_reg[p]) begin
        pipe_reg[p][0] <= data_reg[p];
        for (int s = 1; s < DEPTH; s++) begin
          pipe_reg[p][s] <= pipe_reg[p][s-1];
        end
      end
      // With the enable high the stages hold and the port value is dropped.
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        operand_reg[p] <= DATA_RESET;
      end else if (advance) begin
        // Code 0 picks the newest stage (one clock), code 15 the oldest.
        operand_reg[p] <= pipe_reg[p][sel_reg[p]];
      end
    end
  end

  // Controls travel a fixed pipe, whatever the delay codes.
  // Pipe, operand and product stages are matched one for one, so code-0 data
  // meets the controls that were captured with it.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_op_reg <= CTRL_RESET;
      ctrl_mul_reg <= CTRL_RESET;
      ctrl_prod_reg <= CTRL_RESET;
      ctrl_sum_reg <= CTRL_RESET;
    end else if (advance) begin
      ctrl_op_reg <= ctrl_reg;
      ctrl_mul_reg <= ctrl_op_reg;
      ctrl_prod_reg <= ctrl_mul_reg;
      ctrl_sum_reg <= ctrl_prod_reg;
    end
  end

  // The cascade word follows the same fixed pipe as the controls.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cas_op_reg <= '0;
      cas_mul_reg <= '0;
      cas_prod_reg <= '0;
      cas_sum_reg <= '0;
    end else if (advance) begin
      cas_op_reg <= cas_reg;
      cas_mul_reg <= cas_op_reg;
      cas_prod_reg <= cas_mul_reg;
      cas_sum_reg <= cas_prod_reg;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prod_ab_reg <= '0;
    end else if (advance) begin
      prod_ab_reg <= $signed(operand_reg[0]) * $signed(operand_reg[1]);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prod_cd_reg <= '0;
    end else if (advance) begin
      prod_cd_reg <= $signed(operand_reg[2]) * $signed(operand_reg[3]);
    end
  end

  always_comb begin
    sum_next = ACC_W'(ctrl_prod_reg.negate_first_product ? -prod_ab_reg : prod_ab_reg);
    if (ctrl_prod_reg.negate_second_product) begin
      sum_next = sum_next - ACC_W'(prod_cd_reg);
    end else begin
      sum_next = sum_next + ACC_W'(prod_cd_reg);
    end
    // Rounding is only applied when a new accumulation starts.
    if (ctrl_prod_reg.round_control && !ctrl_prod_reg.accumulate_control) begin
      sum_next = sum_next + ROUND_ADD;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sum_reg <= ACC_RESET;
    end else if (advance) begin
      sum_reg <= sum_next;
    end
  end

  always_comb begin
    cas_term = ctrl_sum_reg.cascade_enable_n ? ACC_RESET : {cas_sum_reg, 8'h00};
    if (ctrl_sum_reg.accumulate_control) begin
      acc_next = acc_reg + sum_reg + cas_term;
    end else begin
      acc_next = sum_reg + cas_term;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_reg <= ACC_RESET;
    end else if (advance) begin
      acc_reg <= acc_next;
    end
  end

  // Marks one clock before the accumulator first holds a result of captured inputs.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fill_reg <= '0;
    end else if (advance) begin
      fill_reg <= {fill_reg[FILL_STAGES-2:0], 1'b1};
    end
  end

  dmx_fifo #(
    .WIDTH(ACC_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(fill_reg[FILL_STAGES-1]),
    .in_ready_out(advance),
    .in_data_in(acc_reg),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_out_ready),
    .out_data_out(fifo_out_data)
  );

  // New results enter the output pair only while the swap control is high.
  assign fifo_out_ready = swap_reg;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      word_reg <= ACC_RESET;
    end else if (swap_reg && fifo_out_valid) begin
      word_reg <= fifo_out_data;
    end
  end

  // The first toggle clock after swap goes low shows the low word.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      show_lsw_reg <= 1'b0;
    end else begin
      show_lsw_reg <= swap_reg ? 1'b0 : !show_lsw_reg;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sum_reg_out <= SUM_RESET;
    end else if (!swap_reg) begin
      sum_reg_out <= show_lsw_reg ? word_reg[MSW_LSB +: OUT_W]
                                  : word_reg[LSW_LSB +: OUT_W];
    end else if (fifo_out_valid) begin
      sum_reg_out <= fifo_out_data[MSW_LSB +: OUT_W];
    end else begin
      sum_reg_out <= word_reg[MSW_LSB +: OUT_W];
    end
  end

  // Valid rises with the first loaded result and then stays high.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sum_valid_reg <= 1'b0;
    end else if (swap_reg && fifo_out_valid) begin
      sum_valid_reg <= 1'b1;
    end
  end

  assign sum_out = sum_reg_out;
  assign sum_valid_out = sum_valid_reg;
  assign sum_oe_out = !output_enable_n_in;
endmodule

/* File: dmx_bus_model.sv */
// Downstream bus model that only sees the sum word while the mixer drives it.
module dmx_bus_model (
  input wire logic [15:0] sum_in,
  input wire logic oe_in,
  output logic [15:0] bus_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] last_reg = 16'h0000;
  always @(sum_in or oe_in) if (oe_in) last_reg = sum_in;
  // A released bus shows the inverse of the last driven word, never a stale copy.
  assign bus_out = oe_in ? sum_in : ~last_reg;
endmodule

/* File: dmx_mixer_checker.sv */
// Port-level assertions for the mixer datapath.
module dmx_checker import dmx_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire dmx_ports_t port_data_in,
  input wire logic [NPORT-1:0] port_input_enables_n_in,
  input wire dmx_ctrl_t ctrl_in,
  input wire logic word_swap_in,
  input wire logic output_enable_n_in,
  input wire logic core_ready_out,
  input wire logic [OUT_W-1:0] sum_out,
  input wire logic sum_oe_out,
  input wire logic sum_valid_out
);
  logic [5:0] idle_reg;
  logic [2:0] cyc_reg;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Counts edges since reset, and cycles of all-zero traffic that the core accepted.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      idle_reg <= 6'h00;
      cyc_reg <= 3'h0;
    end else begin
      if (cyc_reg != 3'h7) cyc_reg <= cyc_reg + 3'h1;
      if (port_data_in != '0 || port_input_enables_n_in != '0 || !word_swap_in
          || !ctrl_in.cascade_enable_n || ctrl_in.accumulate_control) idle_reg <= 6'h00;
      else if (core_ready_out && idle_reg != 6'h3f) idle_reg <= idle_reg + 6'h1;
    end
  end
  property p_oe; sum_oe_out == !output_enable_n_in; endproperty
  a_oe: assert property (p_oe) else $error("sum drive not tied to enable");
  property p_toggle; !word_swap_in [*3] |=> ##1 sum_out == $past(sum_out, 2); endproperty
  a_toggle: assert property (p_toggle) else $error("words not alternating");
  property p_ready; word_swap_in [*4] |-> core_ready_out; endproperty
  a_ready: assert property (p_ready) else $error("core stalled while draining");
  property p_sticky; sum_valid_out |=> sum_valid_out; endproperty
  a_sticky: assert property (p_sticky) else $error("valid dropped");
  property p_load; $changed(sum_out) |-> sum_valid_out; endproperty
  a_load: assert property (p_load) else $error("sum moved before valid");
  property p_idle; idle_reg >= 6'h28 |-> sum_out == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("zero traffic gave nonzero sum");
  property p_first; cyc_reg < 3'h5 |-> !sum_valid_out; endproperty
  a_first: assert property (p_first) else $error("result too early");
  property p_reset;
    disable iff (1'b0) !rst_n_in |-> sum_out == 16'h0000 && !sum_valid_out && core_ready_out;
  endproperty
  a_reset: assert property (p_reset) else $error("bad outputs in reset");
endmodule

/* File: dmx_mixer_tb.sv */
// Self-checking bench for the mixer datapath.
module dmx_mixer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dmx_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b1;
  logic swap = 1'b1;
  logic oe_n = 1'b0;
  dmx_ports_t pd = '0;
  dmx_sels_t sel = '0;
  logic [3:0] en_n = 4'h0;
  dmx_ctrl_t ctrl = CTRL_RESET;
  logic [15:0] cas = 16'h0000;
  logic [15:0] sum;
  logic [15:0] bus;
  logic [23:0] e;
  logic rdy, oe, vld;
  int mismatches = 0;
  int cmp_count = 0;
  int n0, n;
  int codes[3] = '{0, 7, 15};
  always #5 clk_in = ~clk_in;
  dmx_mixer dut_u (.clk_in, .rst_n_in, .port_data_in(pd), .port_delay_selects_in(sel),
    .port_input_enables_n_in(en_n), .ctrl_in(ctrl), .cascade_data_in(cas),
    .word_swap_in(swap), .output_enable_n_in(oe_n), .core_ready_out(rdy), .sum_out(sum),
    .sum_oe_out(oe), .sum_valid_out(vld));
  dmx_bus_model bus_u (.sum_in(sum), .oe_in(oe), .bus_out(bus));
  task automatic tick;
    @(posedge clk_in);
    #1;
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_for(input logic [15:0] exp, output int k);
    k = 0;
    while (sum !== exp && k < 60) begin
      tick();
      k++;
    end
    if (sum !== exp) begin
      chk(sum, exp);
      wrap_up();
    end
  endtask
  // One sample of traffic; port B keeps its value so a delayed A still meets it.
  task automatic shot(input dmx_ports_t v, input dmx_ctrl_t c, input logic [15:0] cv,
      input logic [15:0] exp, output int k);
    pd = v;
    ctrl = c;
    cas = cv;
    tick();
    pd = '0;
    pd[1] = v[1];
    ctrl = CTRL_RESET;
    cas = 16'h0000;
    wait_for(exp, k);
    chk(sum, exp);
    pd = '0;
    repeat (24) tick();
  endtask
  initial begin
    rst_n_in = 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    repeat (45) tick();
    chk(sum, 16'h0000);
    chk({15'h0, vld}, 16'h0001);
    for (int i = 0; i < 3; i++) begin
      sel[0] = 4'(codes[i]);
      shot({24'h0, 12'h010, 12'h123}, 5'b00001, 16'h0000, 16'h0012, n);
      if (i == 0) n0 = n;
      chk(16'(n - n0), 16'(codes[i]));
    end
    sel = '0;
    for (int i = 0; i < 4; i++) begin
      e = (i[1] ? -24'h030000 : 24'h030000) + (i[0] ? -24'h010000 : 24'h010000);
      shot({12'h100, 12'h100, 12'h100, 12'h300}, {i[1:0], 3'b001}, 16'h0, e[23:8], n);
    end
    shot({24'h0, 12'h080, 12'h003}, 5'b00101, 16'h0000, 16'h0002, n);
    shot('0, 5'b00000, 16'h0012, 16'h0012, n);
    shot({24'h0, 12'h100, 12'h500}, 5'b00001, 16'h0034, 16'h0500, n);
    pd = {24'h0, 12'h080, 12'h003};
    ctrl = 5'b00101;
    tick();
    shot({24'h0, 12'h080, 12'h003}, 5'b00111, 16'h0000, 16'h0003, n);
    en_n = 4'h1;
    pd = {24'h0, 12'h010, 12'h123};
    repeat (30) tick();
    chk(sum, 16'h0000);
    en_n = 4'h0;
    wait_for(16'h0012, n);
    oe_n = 1'b1;
    #1;
    chk(bus, 16'hffed);
    oe_n = 1'b0;
    #1;
    chk(bus, 16'h0012);
    swap = 1'b0;
    wait_for(16'h1230, n);
    chk(sum, 16'h1230);
    tick();
    chk(sum, 16'h0012);
    tick();
    chk(sum, 16'h1230);
    repeat (12) tick();
    chk({15'h0, rdy}, 16'h0000);
    swap = 1'b1;
    wait_for(16'h0012, n);
    chk(sum, 16'h0012);
    wrap_up();
  end
endmodule
bind dmx_mixer dmx_checker chk_u (.clk_in, .rst_n_in, .port_data_in, .port_input_enables_n_in,
  .ctrl_in, .word_swap_in, .output_enable_n_in, .core_ready_out, .sum_out, .sum_oe_out,
  .sum_valid_out);
